//--- rtl/sdcal_corr_mem.sv
// per-channel gain and offset correction store with registered read
`timescale 1ns/1ps
`default_nettype none

module sdcal_corr_mem (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // write port
   input wire logic we_gain_i,
   input wire logic we_off_i,
   input wire logic [sdcal_pkg::CW-1:0] waddr_i,
   input wire logic [sdcal_pkg::DW-1:0] wgain_i,
   input wire logic [sdcal_pkg::DW-1:0] woff_i,
   // read port
   input wire logic [sdcal_pkg::CW-1:0] raddr_i,
   output logic [sdcal_pkg::DW-1:0] rgain_o,
   output logic [sdcal_pkg::DW-1:0] roff_o
);
   import sdcal_pkg::*;

   logic [DW-1:0] gain_mem [NCH];
   logic [DW-1:0] off_mem [NCH];

   // ==========================================================
   // storage, cleared so a read before calibration is defined
   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < NCH; i++) begin
         if (!rst_n_i) begin
            gain_mem[i] <= ZERO_WORD;
            off_mem[i] <= ZERO_WORD;
         end else if (waddr_i == CW'(i)) begin
            if (we_gain_i) begin
               gain_mem[i] <= wgain_i;
            end
            if (we_off_i) begin
               off_mem[i] <= woff_i;
            end
         end
      end
   end

   // ==========================================================
   // registered read; out-of-range address reads zero
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rgain_o <= ZERO_WORD;
         roff_o <= ZERO_WORD;
      end else if (raddr_i < CHAN_END) begin
         rgain_o <= gain_mem[raddr_i];
         roff_o <= off_mem[raddr_i];
      end else begin
         rgain_o <= ZERO_WORD;
         roff_o <= ZERO_WORD;
      end
   end

endmodule : sdcal_corr_mem
`default_nettype wire

//--- rtl/sdcal_ctrl.sv
// calibration sequencer, result freeze and analog power-up wait
`timescale 1ns/1ps
`default_nettype none

module sdcal_ctrl (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // calibration control
   input wire logic cal_start_bit_i,
   input wire logic [1:0] cal_mode_field_i,
   input wire logic [sdcal_pkg::NCH-1:0] channel_cal_enable_i,
   input wire logic [sdcal_pkg::NCH-1:0] input_type_select_i,
   output logic cal_status_flag_o,
   output logic cal_done_interrupt_o,
   // power-up and conversion trigger
   input wire logic converter_power_on_i,
   input wire logic conv_trigger_i,
   output logic power_ready_o,
   output logic conv_trig_o,
   // modulator side
   output logic conv_req_o,
   output logic [sdcal_pkg::CW-1:0] conv_chan_o,
   output logic [1:0] cal_input_sel_o,
   input wire logic conv_done_i,
   input wire logic [sdcal_pkg::CW-1:0] conv_chan_i,
   input wire logic conv_status_i,
   input wire logic [sdcal_pkg::DW-1:0] conv_data_i,
   // conversion result
   output logic [sdcal_pkg::CW-1:0] result_channel_num_o,
   output logic result_status_bit_o,
   output logic [sdcal_pkg::DW-1:0] result_value_o,
   // correction value access
   input wire logic cal_protect_bit_i,
   input wire logic corr_wr_gain_i,
   input wire logic corr_wr_off_i,
   input wire logic [sdcal_pkg::CW-1:0] corr_addr_i,
   input wire logic [sdcal_pkg::DW-1:0] corr_wdata_i,
   output logic [sdcal_pkg::DW-1:0] corr_gain_o,
   output logic [sdcal_pkg::DW-1:0] corr_off_o,
   output logic corr_blocked_o
);
   import sdcal_pkg::*;

   sdcal_state_t state;
   logic [1:0] mode;
   logic [NCH-1:0] mask;
   logic [CW-1:0] chan;
   logic gain_phase;
   logic [ACC_SH:0] nconv;
   logic signed [DW+ACC_SH-1:0] acc;
   logic signed [DW-1:0] off_avg;
   logic signed [DW-1:0] avg;
   logic cal_busy, cal_take, sw_ok;
   logic cal_we_off, cal_we_gain, mem_we_off, mem_we_gain;
   logic [DW-1:0] cal_off_word, cal_gain_word, mem_woff, mem_wgain;
   logic [CW-1:0] mem_addr;
   logic pwr_q, trig_pend;
   logic [9:0] pwr_cnt;

   // ==========================================================
   // sequencer decodes
   assign cal_busy = (state != ST_IDLE);
   assign cal_take = !cal_busy && cal_start_bit_i && power_ready_o
                     && (cal_mode_field_i != MODE_RSVD);
   assign avg = acc[DW+ACC_SH-1:ACC_SH];
   assign cal_we_off = (state == ST_STORE) && !gain_phase;
   assign cal_we_gain = (state == ST_STORE) && gain_phase;
   assign cal_off_word = DW'(-avg);
   assign cal_gain_word = DW'(GAIN_TARGET - DW'(avg - off_avg));
   // software writes only under protection and never during a run
   assign sw_ok = cal_protect_bit_i && !cal_busy;
   assign mem_we_off = cal_we_off || (corr_wr_off_i && sw_ok);
   assign mem_we_gain = cal_we_gain || (corr_wr_gain_i && sw_ok);
   assign mem_woff = cal_busy ? cal_off_word : corr_wdata_i;
   assign mem_wgain = cal_busy ? cal_gain_word : corr_wdata_i;
   assign mem_addr = cal_busy ? chan : corr_addr_i;

   sdcal_corr_mem u_mem (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .we_gain_i(mem_we_gain),
      .we_off_i(mem_we_off),
      .waddr_i(mem_addr),
      .wgain_i(mem_wgain),
      .woff_i(mem_woff),
      .raddr_i(mem_addr),
      .rgain_o(corr_gain_o),
      .roff_o(corr_off_o)
   );

   // ==========================================================
   // calibration sequencer: walks enabled differential channels
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         mode <= MODE_INT;
         mask <= '0;
         chan <= '0;
         gain_phase <= 1'b0;
         nconv <= '0;
         acc <= '0;
         off_avg <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cal_take) begin
                  mode <= cal_mode_field_i;
                  mask <= channel_cal_enable_i & ~input_type_select_i;
                  chan <= '0;
                  state <= ST_PICK;
               end
            end
            ST_PICK: begin
               if (chan == CHAN_END) begin
                  state <= ST_DONE;
               end else if (mask[chan]) begin
                  gain_phase <= (mode == MODE_EXT_GAIN);
                  nconv <= '0;
                  acc <= '0;
                  state <= (mode == MODE_EXT_GAIN) ? ST_LOAD : ST_REQ;
               end else begin
                  chan <= chan + 3'h1;
               end
            end
            // the stored offset correction is the negated offset reading
            ST_LOAD: begin
               off_avg <= DW'(-$signed(corr_off_o));
               state <= ST_REQ;
            end
            ST_REQ: begin
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               if (conv_done_i) begin
                  acc <= acc + (DW+ACC_SH)'($signed(conv_data_i));
                  nconv <= nconv + 3'h1;
                  state <= (nconv == CAL_LAST_CONV) ? ST_STORE : ST_REQ;
               end
            end
            ST_STORE: begin
               if (!gain_phase && (mode == MODE_INT)) begin
                  off_avg <= avg;
                  gain_phase <= 1'b1;
                  nconv <= '0;
                  acc <= '0;
                  state <= ST_REQ;
               end else if (mode == MODE_INT) begin
                  chan <= chan + 3'h1;
                  state <= ST_PICK;
               end else begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // status flag and completion pulse
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cal_status_flag_o <= 1'b0;
         cal_done_interrupt_o <= 1'b0;
      end else begin
         cal_done_interrupt_o <= (state == ST_DONE);
         if (cal_take) begin
            cal_status_flag_o <= 1'b1;
         end else if (state == ST_DONE) begin
            cal_status_flag_o <= 1'b0;
         end
      end
   end

   // ==========================================================
   // modulator requests; internal mode feeds zero then reference
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         conv_req_o <= 1'b0;
         conv_chan_o <= '0;
         cal_input_sel_o <= CAL_IN_PINS;
      end else begin
         conv_req_o <= (state == ST_REQ);
         conv_chan_o <= chan;
         if (cal_busy && (mode == MODE_INT)) begin
            cal_input_sel_o <= gain_phase ? CAL_IN_REF : CAL_IN_ZERO;
         end else begin
            cal_input_sel_o <= CAL_IN_PINS;
         end
      end
   end

   // ==========================================================
   // result register, frozen while a run is active
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         result_channel_num_o <= '0;
         result_status_bit_o <= 1'b0;
         result_value_o <= ZERO_WORD;
      end else if (conv_done_i && !cal_busy) begin
         result_channel_num_o <= conv_chan_i;
         result_status_bit_o <= conv_status_i;
         result_value_o <= conv_data_i;
      end
   end

   // ==========================================================
   // stabilization wait after converter power-on; counts from the rise
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pwr_q <= 1'b0;
         pwr_cnt <= '0;
         power_ready_o <= 1'b0;
      end else begin
         pwr_q <= converter_power_on_i;
         if (!converter_power_on_i) begin
            pwr_cnt <= '0;
            power_ready_o <= 1'b0;
         end else if (!pwr_q) begin
            pwr_cnt <= PWR_WAIT_CYC;
            power_ready_o <= 1'b0;
         end else if (pwr_cnt == PWR_CNT_LAST) begin
            pwr_cnt <= '0;
            power_ready_o <= 1'b1;
         end else if (pwr_cnt != '0) begin
            pwr_cnt <= pwr_cnt - 10'h001;
         end
      end
   end

   // ==========================================================
   // triggers held until settled and not calibrating; triggers while power is off are dropped
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         trig_pend <= 1'b0;
         conv_trig_o <= 1'b0;
      end else begin
         conv_trig_o <= power_ready_o && !cal_busy && (conv_trigger_i || trig_pend);
         if (!converter_power_on_i || (power_ready_o && !cal_busy)) begin
            trig_pend <= 1'b0;
         end else if (conv_trigger_i) begin
            trig_pend <= 1'b1;
         end
      end
   end

   // write refused for lack of protection or during a run
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         corr_blocked_o <= 1'b0;
      end else begin
         corr_blocked_o <= (corr_wr_gain_i || corr_wr_off_i) && !sw_ok;
      end
   end

   // ==========================================================
   // checks
   localparam int PWR_CHK = 1000;
   logic [10:0] since_pwr;
   logic [3:0] run_wr;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !converter_power_on_i) begin
         since_pwr <= '0;
      end else if (since_pwr != 11'h7FF) begin
         since_pwr <= since_pwr + 11'h001;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || cal_take) begin
         run_wr <= '0;
      end else if (cal_we_off || cal_we_gain) begin
         run_wr <= run_wr + 4'h1;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_start_taken;
      cal_take;
   endsequence
   sequence s_flag_up;
      ##1 cal_status_flag_o [*2];
   endsequence

   chk_start_flag_rise: assert property (s_start_taken |-> s_flag_up)
      else $error("status flag did not rise after start");
   chk_done_flag_fall: assert property (cal_done_interrupt_o
         |-> !cal_status_flag_o && $past(cal_status_flag_o))
      else $error("completion pulse without flag fall");
   chk_result_frozen: assert property (cal_status_flag_o && $past(cal_status_flag_o)
         |-> $stable(result_value_o) && $stable(result_channel_num_o))
      else $error("result changed during calibration");
   chk_power_wait_len: assert property (power_ready_o |-> since_pwr >= 11'(PWR_CHK))
      else $error("ready before stabilization wait elapsed");
   chk_trig_after_wait: assert property (conv_trig_o |-> $past(power_ready_o))
      else $error("conversion trigger during stabilization wait");
   chk_diff_only_write: assert property ((cal_we_off || cal_we_gain) |-> mask[chan])
      else $error("correction written for a non-target channel");
   chk_int_ref_input: assert property (conv_req_o && mode == MODE_INT && gain_phase
         |-> cal_input_sel_o == CAL_IN_REF)
      else $error("internal gain phase without reference input");
   chk_ext_gain_mode: assert property (state == ST_REQ && mode == MODE_EXT_GAIN
         |-> gain_phase && $past(state, 2) != ST_IDLE)
      else $error("external gain run measured an offset phase");
   chk_ext_one_chan: assert property (cal_done_interrupt_o && mode != MODE_INT
         |-> run_wr <= 4'h1)
      else $error("external run wrote more than one correction");
   chk_protect_block: assert property (corr_wr_off_i && !cal_protect_bit_i
         |=> corr_blocked_o)
      else $error("unprotected correction write not refused");

endmodule : sdcal_ctrl
`default_nettype wire

//--- rtl/sdcal_pkg.sv
// constants, types and operating summary for the sigma-delta calibration control
//
// Summary of operation
// - a calibration run starts on a one written to the start bit
// - mode field: 00 internal, 01 external offset, 10 external gain
// - single-ended channels never receive offset or gain correction values
// - result channel, status and value do not update during calibration
// - internal mode uses internal zero and reference inputs for all enabled differential channels
// - completion interrupt marks the end of every calibration run
// - offset correction drives the offset-input result to exactly zero
// - gain correction maps gain input minus offset input to 2^23-1
// - external runs handle one channel; offset and gain are separate runs
// - saved corrections may be written back while settings are unchanged
// - correction writes are accepted only while the protect bit is one
// - hardware times the stabilization wait after converter power-on
// - the wait lasts 20 us; triggers during it are deferred

package sdcal_pkg;

   // ==========================================================
   // sizes
   localparam int NCH = 5;
   localparam int DW = 24;
   localparam int CW = 3;
   localparam int ACC_SH = 2;
   localparam logic [CW-1:0] CHAN_END = 3'h5;
   localparam logic [ACC_SH:0] CAL_LAST_CONV = 3'h3;

   // ==========================================================
   // mode field and calibration input selection
   localparam logic [1:0] MODE_INT = 2'h0;
   localparam logic [1:0] MODE_EXT_OFF = 2'h1;
   localparam logic [1:0] MODE_EXT_GAIN = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;
   localparam logic [1:0] CAL_IN_PINS = 2'h0;
   localparam logic [1:0] CAL_IN_ZERO = 2'h1;
   localparam logic [1:0] CAL_IN_REF = 2'h2;

   // ==========================================================
   // values
   localparam logic [DW-1:0] GAIN_TARGET = 24'h7FFFFF;
   localparam logic [DW-1:0] ZERO_WORD = 24'h000000;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int PWR_WAIT_NS = 20000;
   localparam logic [9:0] PWR_WAIT_CYC = 10'((PWR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] PWR_CNT_LAST = 10'h001;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_PICK, ST_LOAD, ST_REQ, ST_WAIT, ST_STORE, ST_DONE
   } sdcal_state_t;

endpackage : sdcal_pkg

//--- test/sdcal_ctrl_bench.sv
// self-checking bench for the calibration sequencer, result freeze and power wait
`timescale 1ns/1ps
`default_nettype none

module sdcal_ctrl_bench;
   import sdcal_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start = 1'b0, pwr = 1'b0, trg = 1'b0, prot = 1'b0, wg = 1'b0, wo = 1'b0, fgo = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [NCH-1:0] en = 5'h00, styp = 5'h00;
   logic [CW-1:0] caddr = 3'h0;
   logic [DW-1:0] cdata = 24'h000000, pin = 24'h000000;
   logic [3:0] dly = 4'h1;
   logic flag, irq, rdy, trg_o, req, rstat, mdone, mstat, blk;
   logic [CW-1:0] rchan, mchan, rch;
   logic [1:0] csel;
   logic [DW-1:0] mdata, rval, cg, co;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;

   always #10 mclk_i = ~mclk_i;

   sdcal_ctrl dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cal_start_bit_i(start),
      .cal_mode_field_i(mode), .channel_cal_enable_i(en), .input_type_select_i(styp),
      .cal_status_flag_o(flag), .cal_done_interrupt_o(irq), .converter_power_on_i(pwr),
      .conv_trigger_i(trg), .power_ready_o(rdy), .conv_trig_o(trg_o), .conv_req_o(req),
      .conv_chan_o(rch), .cal_input_sel_o(csel), .conv_done_i(mdone), .conv_chan_i(mchan),
      .conv_status_i(mstat), .conv_data_i(mdata), .result_channel_num_o(rchan),
      .result_status_bit_o(rstat), .result_value_o(rval), .cal_protect_bit_i(prot),
      .corr_wr_gain_i(wg), .corr_wr_off_i(wo), .corr_addr_i(caddr), .corr_wdata_i(cdata),
      .corr_gain_o(cg), .corr_off_o(co), .corr_blocked_o(blk));

   sdcal_mod_model model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .conv_req_i(req),
      .conv_chan_i(rch), .cal_input_sel_i(csel), .pin_level_i(pin), .delay_i(dly),
      .free_go_i(fgo), .conv_done_o(mdone), .conv_chan_o(mchan), .conv_status_o(mstat),
      .conv_data_o(mdata));

   // ==========================================================
   // shared tasks
   task automatic results();
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // read one correction entry; data is registered one cycle after the address
   task automatic rd_corr(input logic [CW-1:0] a, input logic [DW-1:0] eg, input logic [DW-1:0] eo);
      @(posedge mclk_i);
      caddr <= a;
      @(posedge mclk_i);
      #1;
      chk(cg, eg, "gain correction");
      chk(co, eo, "offset correction");
   endtask : rd_corr

   task automatic wr_corr(input logic p, input logic [CW-1:0] a, input logic [DW-1:0] d,
      input logic eb);
      @(posedge mclk_i);
      {wg, wo, prot, caddr, cdata} <= {1'b1, 1'b1, p, a, d};
      @(posedge mclk_i);
      {wg, wo} <= 2'h0;
      #1;
      chk(blk, eb, "write refusal");
   endtask : wr_corr

   // one calibration start; checks flag, first request, done pulse and frozen result
   task automatic run_cal(input logic [1:0] m, input logic [NCH-1:0] e, input logic ef,
      input logic [1:0] es, input logic [CW-1:0] ec);
      logic [DW-1:0] keep;
      logic seen;
      int n;
      keep = rval;
      seen = 1'b0;
      n = 0;
      @(posedge mclk_i);
      {mode, en, start} <= {m, e, 1'b1};
      @(posedge mclk_i);
      start <= 1'b0;
      #1;
      chk(flag, ef, "status flag after start");
      while (ef && irq !== 1'b1 && n < 400) begin
         @(posedge mclk_i);
         #1;
         n++;
         if (req === 1'b1 && !seen) begin
            seen = 1'b1;
            chk(csel, es, "calibration input");
            chk(rch, ec, "calibration channel");
         end
      end
      if (ef) begin
         chk(irq, 1'b1, "completion pulse");
         chk(flag, 1'b0, "flag cleared with pulse");
         @(posedge mclk_i);
         #1;
         chk(irq, 1'b0, "pulse length");
      end else begin
         repeat (6) @(posedge mclk_i);
         #1;
         chk(irq, 1'b0, "refused start");
      end
      chk(rval, keep, "result frozen");
   endtask : run_cal

   // ==========================================================
   // hang guard
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         $display("Error at %0t: run did not finish", $time);
         results();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      int n;
      logic early;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      chk({20'h00000, flag, irq, rdy, trg_o}, 24'h000000, "flags after reset");
      chk(rval, ZERO_WORD, "result after reset");
      run_cal(MODE_INT, 5'h1F, 1'b0, CAL_IN_ZERO, 3'h0);
      // power-up: a trigger inside the wait is held until the wait ends
      // clock and settings are taken as already up, bandgap wait elapsed
      @(posedge mclk_i);
      pwr <= 1'b1;
      n = 0;
      early = 1'b0;
      while (rdy !== 1'b1 && n < 1100) begin
         @(posedge mclk_i);
         trg <= (n == 10);
         #1;
         if (trg_o === 1'b1) early = 1'b1;
         n++;
      end
      chk(DW'(n >= 1000 && n <= 1002), 24'h1, "stabilization wait length");
      chk(DW'(early), 24'h0, "trigger during wait");
      @(posedge mclk_i);
      #1;
      chk(trg_o, 1'b1, "deferred trigger");
      // software conversion reaches the result register outside calibration
      @(posedge mclk_i);
      {pin, fgo} <= {24'h345678, 1'b1};
      @(posedge mclk_i);
      fgo <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1;
      chk({20'h00000, rchan, rstat}, {20'h00000, 3'h4, 1'b1}, "result channel");
      chk(rval, 24'h345678, "result register");
      // internal run: ch2 single-ended, ch3 not enabled
      // single scan and zero offset codes are kept by software throughout
      styp <= 5'b00100;
      run_cal(MODE_INT, 5'b10111, 1'b1, CAL_IN_ZERO, 3'h0);
      for (int c = 0; c < NCH; c++) begin
         if (c == 2 || c == 3) rd_corr(CW'(c), ZERO_WORD, ZERO_WORD);
         else rd_corr(CW'(c), 24'h10000F, 24'h0 - 24'h10 - DW'(c));
      end
      // external offset then gain on ch1, slow modulator
      dly <= 4'h6;
      pin <= 24'h000123;
      run_cal(MODE_EXT_OFF, 5'b00010, 1'b1, CAL_IN_PINS, 3'h1);
      rd_corr(3'h1, 24'h10000F, 24'hFFFEDD);
      pin <= 24'h500123;
      run_cal(MODE_EXT_GAIN, 5'b00010, 1'b1, CAL_IN_PINS, 3'h1);
      rd_corr(3'h1, 24'h2FFFFF, 24'hFFFEDD);
      run_cal(MODE_RSVD, 5'b00001, 1'b0, CAL_IN_PINS, 3'h0);
      run_cal(MODE_INT, 5'h00, 1'b1, CAL_IN_ZERO, 3'h0);
      // saved values written back only with protection open
      wr_corr(1'b0, 3'h0, 24'h123456, 1'b1);
      rd_corr(3'h0, 24'h10000F, 24'hFFFFF0);
      wr_corr(1'b1, 3'h4, 24'hABCDEF, 1'b0);
      rd_corr(3'h4, 24'hABCDEF, 24'hABCDEF);
      // trigger while ready and idle passes one cycle later
      @(posedge mclk_i);
      trg <= 1'b1;
      @(posedge mclk_i);
      trg <= 1'b0;
      #1;
      chk(trg_o, 1'b1, "direct trigger");
      @(posedge mclk_i);
      pwr <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      chk(rdy, 1'b0, "ready after power off");
      results();
   end
endmodule : sdcal_ctrl_bench
`default_nettype wire

//--- test/sdcal_mod_model.sv
// behavioural modulator with internal calibration inputs for the calibration control
`timescale 1ns/1ps
`default_nettype none

module sdcal_mod_model
   import sdcal_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // requests from the control block
   input wire logic conv_req_i,
   input wire logic [sdcal_pkg::CW-1:0] conv_chan_i,
   input wire logic [1:0] cal_input_sel_i,
   // bench side
   input wire logic [sdcal_pkg::DW-1:0] pin_level_i,
   input wire logic [3:0] delay_i,
   input wire logic free_go_i,
   // answers
   output logic conv_done_o,
   output logic [sdcal_pkg::CW-1:0] conv_chan_o,
   output logic conv_status_o,
   output logic [sdcal_pkg::DW-1:0] conv_data_o
);
   // ==========================================================
   // input chosen for the running conversion
   logic busy;
   logic [3:0] wait_cnt;
   logic [1:0] sel;
   logic [DW-1:0] sample;

   // internal zero and reference levels differ per channel to catch mixups
   always_comb begin
      case (sel)
         CAL_IN_ZERO: sample = 24'h000010 + {21'h000000, conv_chan_o};
         CAL_IN_REF: sample = 24'h700000 + {21'h000000, conv_chan_o};
         default: sample = pin_level_i;
      endcase
   end

   // ==========================================================
   // answer after a settable delay; data lines garbled between answers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         busy <= 1'b0;
         wait_cnt <= 4'h0;
         sel <= 2'h0;
         conv_done_o <= 1'b0;
         conv_status_o <= 1'b0;
         conv_chan_o <= 3'h0;
         conv_data_o <= 24'h000000;
      end else begin
         conv_done_o <= 1'b0;
         conv_data_o <= ~conv_data_o;
         if (conv_req_i) begin
            busy <= 1'b1;
            wait_cnt <= delay_i;
            sel <= cal_input_sel_i;
            conv_chan_o <= conv_chan_i;
         end else if (busy && wait_cnt == 4'h0) begin
            busy <= 1'b0;
            conv_done_o <= 1'b1;
            conv_status_o <= 1'b0;
            conv_data_o <= sample;
         end else if (busy) begin
            wait_cnt <= wait_cnt - 4'h1;
         end else if (free_go_i) begin
            // software conversion, only while no calibration request is open
            conv_done_o <= 1'b1;
            conv_status_o <= 1'b1;
            conv_chan_o <= 3'h4;
            conv_data_o <= pin_level_i;
         end
      end
   end
endmodule : sdcal_mod_model
`default_nettype wire
